// ---- shared/ctfl_pkg.sv ----
// Package: constants and types for the current and temperature limit block
package ctfl_pkg;

	// ==========================================================
	// Command codes
	localparam logic [7:0] CMD_OCW  = 8'h4a;
	localparam logic [7:0] CMD_UCF  = 8'h4b;
	localparam logic [7:0] CMD_OTF  = 8'h4f;
	localparam logic [7:0] CMD_OTA  = 8'h50;
	localparam logic [7:0] CMD_WORD = 8'h79;
	localparam logic [7:0] CMD_IOUT = 8'h7b;
	localparam logic [7:0] CMD_TEMP = 8'h7d;
	localparam logic [7:0] CMD_VEND = 8'h80;

	// ==========================================================
	// Values after reset
	localparam logic [15:0] OCW_RST = 16'hf8be; // 190 x 2^-1 = 95A
	localparam logic [15:0] UCF_RST = 16'h07d8; // -40A
	localparam logic [15:0] OTF_RST = 16'h007d; // 125 C
	localparam logic [7:0]  OTA_RST = 8'hb8;

	// ==========================================================
	// Status bit positions
	localparam int IOUT_OCF_BIT  = 7;
	localparam int IOUT_OCW_BIT  = 5;
	localparam int IOUT_UCF_BIT  = 4;
	localparam int TEMP_OTF_BIT  = 7;
	localparam int WORD_IOUT_BIT = 14;
	localparam int WORD_TEMP_BIT = 2;
	localparam int VEND_OT_BIT   = 1;

	// ==========================================================
	// Fixed-point view of limit words: 16 fraction bits
	localparam int FX_W = 48;
	localparam logic [5:0] FX_FRAC = 6'h10;
	localparam logic signed [FX_W-1:0] FX_ZERO    = 48'sh0000_0000_0000;
	localparam logic signed [FX_W-1:0] OCW_MAX_FX = 48'sh0000_0064_0000;
	localparam logic signed [FX_W-1:0] UCF_MIN_FX = 48'shffff_ff9c_0000;
	localparam logic signed [FX_W-1:0] UCF_MAX_FX = 48'sh0000_0064_0000;
	localparam logic signed [FX_W-1:0] OTF_MIN_FX = 48'shffff_ffd8_0000;
	localparam logic signed [FX_W-1:0] OTF_MAX_FX = 48'sh0000_0096_0000;

	// ==========================================================
	// Decoder slots
	localparam int DEC_N = 10;
	localparam int D_PEAK = 0, D_VAL = 1, D_AVG = 2, D_TMP = 3, D_OCW = 4;
	localparam int D_OCF = 5, D_UCF = 6, D_AUC = 7, D_OTW = 8, D_OTF = 9;
	localparam int D_WR = 10;

	// ==========================================================
	// Retry timing
	localparam int CLK_KHZ = 100000;
	localparam int RETRY_UNIT_MS = 35;
	localparam int RETRY_UNIT_CYC = RETRY_UNIT_MS * CLK_KHZ;
	localparam logic [1:0] ACT_RETRY = 2'h2;
	localparam logic [2:0] RETRY_NONE = 3'h0;
	localparam logic [2:0] RETRY_FOREVER = 3'h7;

	// ==========================================================
	// Types
	typedef struct packed {
		logic [1:0] act;
		logic [2:0] retry;
		logic [2:0] delay;
	} ctfl_action_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [7:0]  code;
		logic [15:0] data;
	} ctfl_cmd_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] peak;
		logic [15:0] valley;
		logic [15:0] avg;
		logic [15:0] temp;
	} ctfl_meas_t;

	typedef struct packed {
		logic [15:0] ocFault;
		logic [15:0] avgUc;
		logic [15:0] otWarn;
		logic [7:0]  ucAction;
	} ctfl_ext_t;

	typedef enum logic [1:0] {OT_RUN, OT_OFF, OT_DELAY, OT_COOL} ctfl_ot_t;

endpackage

// ---- logic/ctfl_lin11_dec.sv ----
// Limit word to signed fixed-point converter
`timescale 1ns/1ps
module ctfl_lin11_dec
	import ctfl_pkg::*;
(
	input  wire logic [15:0]            word,
	output logic signed [FX_W-1:0]      fx
);
	logic signed [4:0]  expo;
	logic signed [10:0] mant;
	logic [5:0]         shift;

	// ==========================================================
	// Y x 2^N, shifted so exponent -16 lands on bit 0
	assign expo  = word[15:11];
	assign mant  = word[10:0];
	assign shift = {expo[4], expo} + FX_FRAC;
	assign fx    = FX_W'(mant) <<< shift;
endmodule

// ---- logic/ctfl_retry_timer.sv ----
// Retry delay timer counting whole delay units
`timescale 1ns/1ps
module ctfl_retry_timer
	import ctfl_pkg::*;
#(
	parameter int UNIT_CYCLES = RETRY_UNIT_CYC
) (
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       ce,
	input  wire logic       start,
	input  wire logic [2:0] delaySel,
	output logic            busy,
	output logic            done
);
	logic [31:0] cnt_r;

	// ==========================================================
	// Load (sel+1) units, pulse done in the same cycle busy drops
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= 32'h0000_0000;
			done  <= 1'b0;
		end else if (ce) begin
			done <= 1'b0;
			if (start) begin
				cnt_r <= 32'((32'(delaySel) + 32'h1) * UNIT_CYCLES);
			end else if (cnt_r != 32'h0000_0000) begin
				cnt_r <= cnt_r - 32'h1;
				done  <= (cnt_r == 32'h1);
			end
		end
	end

	assign busy = (cnt_r != 32'h0000_0000);
endmodule

// ---- logic/ctfl_limits.sv ----
// Current and temperature limit registers with fault response
`timescale 1ns/1ps
module ctfl_limits
	import ctfl_pkg::*;
#(
	parameter int RETRY_UNIT_CYCLES = RETRY_UNIT_CYC
) (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        ce,
	input  wire ctfl_cmd_t   cmd,
	input  wire ctfl_meas_t  meas,
	input  wire ctfl_ext_t   ext,
	input  wire logic        clearFaults,
	output logic             rspValid,
	output logic             rspNack,
	output logic [15:0]      rspData,
	output logic             alertN,
	output logic             outputEnable,
	output logic             restartPulse
);
	// ==========================================================
	// Declarations
	logic [15:0]            ocWarnThr_r;
	logic [15:0]            ucThr_r;
	logic [15:0]            otThr_r;
	ctfl_action_t           otAct_r;
	logic [15:0]            wordSt_r;
	logic [7:0]             ioutSt_r;
	logic [7:0]             tempSt_r;
	logic [7:0]             vendSt_r;
	ctfl_ot_t               otState_r;
	logic [2:0]             tries_r;
	logic                   ucOff_r;
	logic                   rspValid_r;
	logic                   rspNack_r;
	logic [15:0]            rspData_r;
	logic                   alertN_r;
	logic                   outEn_r;
	logic                   restartPulse_r;
	logic [15:0]            decIn [DEC_N+1];
	logic signed [FX_W-1:0] decFx [DEC_N+1];
	logic                   sample, wr, ocwHit, ocfHit;
	logic                   ucHit, otHit, coolOk, wrOk;
	logic                   mapped, tmrStart, tmrBusy, tmrDone;
	logic [15:0]            rdMux;
	logic [7:0]             ioutSet;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	// ==========================================================
	// Decode every limit word into one fixed-point form
	assign decIn[D_PEAK] = meas.peak;
	assign decIn[D_VAL]  = meas.valley;
	assign decIn[D_AVG]  = meas.avg;
	assign decIn[D_TMP]  = meas.temp;
	assign decIn[D_OCW]  = ocWarnThr_r;
	assign decIn[D_OCF]  = ext.ocFault;
	assign decIn[D_UCF]  = ucThr_r;
	assign decIn[D_AUC]  = ext.avgUc;
	assign decIn[D_OTW]  = ext.otWarn;
	assign decIn[D_OTF]  = otThr_r;
	assign decIn[D_WR]   = cmd.data;
	for (genvar g = 0; g <= DEC_N; g++) begin : g_dec
		ctfl_lin11_dec u_dec (
			.word (decIn[g]),
			.fx   (decFx[g])
		);
	end
	// ==========================================================
	// Comparisons, only acted on when a sample arrives
	assign sample = ce && meas.valid;
	assign ocwHit = decFx[D_PEAK] > decFx[D_OCW];
	assign ocfHit = decFx[D_PEAK] > decFx[D_OCF];
	assign ucHit  = (decFx[D_VAL] < decFx[D_UCF]) ||
	                (decFx[D_AVG] < decFx[D_AUC]);
	assign otHit  = decFx[D_TMP] > decFx[D_OTF];
	assign coolOk = decFx[D_TMP] < decFx[D_OTW];
	assign wr     = ce && cmd.valid && cmd.write;
	// ==========================================================
	// Write range check on the decoded value
	always_comb begin
		case (cmd.code)
			CMD_OCW: wrOk = (decFx[D_WR] >= FX_ZERO) &&
			                (decFx[D_WR] <= OCW_MAX_FX);
			CMD_UCF: wrOk = (decFx[D_WR] >= UCF_MIN_FX) &&
			                (decFx[D_WR] <= UCF_MAX_FX);
			CMD_OTF: wrOk = (decFx[D_WR] >= OTF_MIN_FX) &&
			                (decFx[D_WR] <= OTF_MAX_FX);
			default: wrOk = 1'b1;
		endcase
	end
	// ==========================================================
	// Read mux; unknown codes answer zero with a refusal
	always_comb begin
		mapped = 1'b1;
		case (cmd.code)
			CMD_OCW:  rdMux = ocWarnThr_r;
			CMD_UCF:  rdMux = ucThr_r;
			CMD_OTF:  rdMux = otThr_r;
			CMD_OTA:  rdMux = {8'h00, otAct_r};
			CMD_WORD: rdMux = wordSt_r;
			CMD_IOUT: rdMux = {8'h00, ioutSt_r};
			CMD_TEMP: rdMux = {8'h00, tempSt_r};
			CMD_VEND: rdMux = {8'h00, vendSt_r};
			default: begin
				rdMux  = 16'h0000;
				mapped = 1'b0;
			end
		endcase
	end
	// ==========================================================
	// Answer one cycle after each command
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rspValid_r <= 1'b0;
			rspNack_r  <= 1'b0;
			rspData_r  <= 16'h0000;
		end else if (ce) begin
			rspValid_r <= cmd.valid;
			rspNack_r  <= cmd.valid && (!mapped || (cmd.write && !wrOk));
			rspData_r  <= (cmd.valid && !cmd.write) ? rdMux : 16'h0000;
		end
	end
	// ==========================================================
	// Limit registers; a refused write leaves the old value
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ocWarnThr_r <= OCW_RST;
			ucThr_r     <= UCF_RST;
			otThr_r     <= OTF_RST;
			otAct_r     <= OTA_RST;
		end else if (wr && wrOk) begin
			case (cmd.code)
				CMD_OCW: ocWarnThr_r <= cmd.data;
				CMD_UCF: ucThr_r <= cmd.data;
				CMD_OTF: otThr_r <= cmd.data;
				CMD_OTA: otAct_r <= cmd.data[7:0];
				default: ;
			endcase
		end
	end
	// ==========================================================
	// Sticky status; set beats a same-cycle clear
	always_comb begin
		ioutSet = 8'h00;
		ioutSet[IOUT_OCW_BIT] = sample && ocwHit;
		ioutSet[IOUT_OCF_BIT] = sample && ocfHit;
		ioutSet[IOUT_UCF_BIT] = sample && ucHit;
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wordSt_r <= 16'h0000;
			ioutSt_r <= 8'h00;
			tempSt_r <= 8'h00;
			vendSt_r <= 8'h00;
		end else if (ce) begin
			if (clearFaults) begin
				wordSt_r <= 16'h0000;
				ioutSt_r <= 8'h00;
				tempSt_r <= 8'h00;
				vendSt_r <= 8'h00;
			end else if (wr) begin
				// Write one to clear
				if (cmd.code == CMD_WORD)
					wordSt_r <= wordSt_r & ~cmd.data;
				if (cmd.code == CMD_IOUT)
					ioutSt_r <= ioutSt_r & ~cmd.data[7:0];
				if (cmd.code == CMD_TEMP)
					tempSt_r <= tempSt_r & ~cmd.data[7:0];
				if (cmd.code == CMD_VEND)
					vendSt_r <= vendSt_r & ~cmd.data[7:0];
			end
			// Per-bit set, so a same-cycle clear still drops the others
			for (int b = 0; b < 8; b++) begin
				if (ioutSet[b])
					ioutSt_r[b] <= 1'b1;
			end
			if (|ioutSet)
				wordSt_r[WORD_IOUT_BIT] <= 1'b1;
			if (sample && otHit) begin
				wordSt_r[WORD_TEMP_BIT] <= 1'b1;
				tempSt_r[TEMP_OTF_BIT]  <= 1'b1;
				vendSt_r[VEND_OT_BIT]   <= 1'b1;
			end
		end
	end
	// ==========================================================
	// Host alert while any status bit is pending
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			alertN_r <= 1'b1;
		else if (ce)
			alertN_r <= !(|wordSt_r || |ioutSt_r ||
			              |tempSt_r || |vendSt_r);
	end
	// ==========================================================
	// Over-temperature response
	assign tmrStart = sample && otHit && (otState_r == OT_RUN) &&
	                  (otAct_r.act == ACT_RETRY) &&
	                  (tries_r != RETRY_NONE);
	ctfl_retry_timer #(
		.UNIT_CYCLES (RETRY_UNIT_CYCLES)
	) u_tmr (
		.clk      (clk),
		.reset_n  (reset_n),
		.ce       (ce),
		.start    (tmrStart),
		.delaySel (otAct_r.delay),
		.busy     (tmrBusy),
		.done     (tmrDone)
	);
	// Attempts reload on a clear or a new action; 7 never runs out
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			otState_r      <= OT_RUN;
			tries_r        <= OTA_RST[5:3];
			restartPulse_r <= 1'b0;
		end else if (ce) begin
			restartPulse_r <= 1'b0;
			if (clearFaults)
				tries_r <= otAct_r.retry;
			else if (wr && cmd.code == CMD_OTA)
				tries_r <= cmd.data[5:3];
			case (otState_r)
				OT_RUN: begin
					if (tmrStart)
						otState_r <= OT_DELAY;
					else if (sample && otHit && otAct_r.act[1])
						otState_r <= OT_OFF;
				end
				OT_DELAY: begin
					if (tmrDone)
						otState_r <= OT_COOL;
				end
				OT_COOL: begin
					if (sample && coolOk) begin
						otState_r      <= OT_RUN;
						restartPulse_r <= 1'b1;
						if (tries_r != RETRY_FOREVER && !clearFaults)
							tries_r <= tries_r - 3'h1;
					end
				end
				OT_OFF: begin
					if (clearFaults)
						otState_r <= OT_RUN;
				end
				default: otState_r <= OT_RUN;
			endcase
		end
	end
	// ==========================================================
	// Undercurrent shutdown shares one action for both checks
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			ucOff_r <= 1'b0;
		else if (ce) begin
			if (sample && ucHit && ext.ucAction[7])
				ucOff_r <= 1'b1;
			else if (clearFaults)
				ucOff_r <= 1'b0;
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			outEn_r <= 1'b1;
		else if (ce)
			outEn_r <= (otState_r == OT_RUN) && !ucOff_r;
	end
	// ==========================================================
	// Outputs, all from flip-flops
	assign rspValid     = rspValid_r;
	assign rspNack      = rspNack_r;
	assign rspData      = rspData_r;
	assign alertN       = alertN_r;
	assign outputEnable = outEn_r;
	assign restartPulse = restartPulse_r;
	// ==========================================================
	// Checks
	sequence s_ot_hit;
		ce && meas.valid && otHit;
	endsequence
	sequence s_ot_flags;
		tempSt_r[TEMP_OTF_BIT] && wordSt_r[WORD_TEMP_BIT] &&
		vendSt_r[VEND_OT_BIT];
	endsequence
	property p_ocw_set;
		sample && ocwHit |=> ioutSt_r[IOUT_OCW_BIT];
	endproperty
	a_ocw_set: assert property (p_ocw_set)
		else $error("warning bit not set on peak crossing");
	property p_ocw_reject;
		wr && cmd.code == CMD_OCW && !wrOk
			|=> $stable(ocWarnThr_r) && rspNack_r;
	endproperty
	a_ocw_reject: assert property (p_ocw_reject)
		else $error("out of range warning threshold accepted");
	property p_uc_set;
		sample && ucHit
			|=> ioutSt_r[IOUT_UCF_BIT] && wordSt_r[WORD_IOUT_BIT];
	endproperty
	a_uc_set: assert property (p_uc_set)
		else $error("undercurrent fault bit not set");
	property p_ot_flags;
		s_ot_hit |=> s_ot_flags;
	endproperty
	a_ot_flags: assert property (p_ot_flags)
		else $error("over-temperature flags not all set");
	property p_ot_alert;
		s_ot_hit ##1 ce |=> !alertN_r;
	endproperty
	a_ot_alert: assert property (p_ot_alert)
		else $error("host not alerted on over-temperature");
	property p_cool_restart;
		restartPulse_r |-> $past(sample && coolOk);
	endproperty
	a_cool_restart: assert property (p_cool_restart)
		else $error("restart while still hot");
	property p_delay_hold;
		tmrBusy |-> otState_r == OT_DELAY && !restartPulse_r;
	endproperty
	a_delay_hold: assert property (p_delay_hold)
		else $error("restart during retry delay");
	property p_thr_reject;
		wr && (cmd.code == CMD_UCF || cmd.code == CMD_OTF) && !wrOk
			|=> $stable(ucThr_r) && $stable(otThr_r);
	endproperty
	a_thr_reject: assert property (p_thr_reject)
		else $error("out of range threshold accepted");
	property p_sticky;
		ioutSt_r[IOUT_OCW_BIT] && !clearFaults &&
		!(wr && cmd.code == CMD_IOUT) |=> ioutSt_r[IOUT_OCW_BIT];
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("status bit dropped without a clear");
endmodule

// ---- sim/ctfl_host_model.sv ----
// Host controller model: decoded commands and host-owned limit inputs
`timescale 1ns/1ps
module ctfl_host_model
	import ctfl_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rspValid,
	input  wire logic        rspNack,
	input  wire logic [15:0] rspData,
	output ctfl_cmd_t        cmd,
	output ctfl_ext_t        ext
);
	// ==================================================
	// Idle bus; oc fault 110A sits above every legal warning
	initial begin
		cmd = '0;
		ext = '{16'h006e, 16'h000a, 16'h003c, 8'h00};
	end

	// ==================================================
	// One command; answer taken at the following edge
	task automatic xfer(input logic w, input logic [7:0] c,
		input logic [15:0] d, output logic ok, output logic n,
		output logic [15:0] q);
		@(posedge clk);
		#1 cmd = '{1'b1, w, c, d};
		@(posedge clk);
		#1 ok = rspValid;
		n = rspNack;
		q = rspData;
		cmd = '{1'b0, 1'b0, ~c, ~d}; // Valid dropped; inverted code and data left on the bus
	endtask
endmodule

// ---- sim/ctfl_limits_bench.sv ----
// Self-checking bench for the current and temperature limit block
`timescale 1ns/1ps
module ctfl_limits_bench
	import ctfl_pkg::*;
;
	// Short retry unit keeps the delay runs brief
	localparam int U = 4;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        ce = 1'b1;
	logic        clearFaults = 1'b0;
	ctfl_cmd_t   cmd;
	ctfl_ext_t   ext;
	ctfl_meas_t  meas = '0;
	logic        rspValid, rspNack, alertN, outputEnable, restartPulse;
	logic [15:0] rspData;
	int          err_count = 0;
	int          checked = 0;
	int          cycles = 0;

	// ==================================================
	// Block and host
	ctfl_limits #(.RETRY_UNIT_CYCLES(U)) DUT (.clk(clk), .reset_n(reset_n),
		.ce(ce), .cmd(cmd), .meas(meas), .ext(ext),
		.clearFaults(clearFaults), .rspValid(rspValid), .rspNack(rspNack),
		.rspData(rspData), .alertN(alertN), .outputEnable(outputEnable),
		.restartPulse(restartPulse));
	ctfl_host_model host (.clk(clk), .rspValid(rspValid),
		.rspNack(rspNack), .rspData(rspData), .cmd(cmd), .ext(ext));

	initial begin
		forever #5 clk = ~clk;
	end

	// Cut a hang short
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			conclude();
		end
	end

	// ==================================================
	// Helpers
	function automatic logic [15:0] lin(input int v);
		return {5'h00, v[10:0]}; // Whole units, exponent zero
	endfunction

	task automatic chk16(input string s, input logic [15:0] e,
		input logic [15:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s exp %h got %h", s, e, g);
		end
	endtask

	task automatic chk1(input string s, input logic e, input logic g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s exp %b got %b", s, e, g);
		end
	endtask

	// Command with expected refusal and answer word
	task automatic acc(input logic w, input logic [7:0] c,
		input logic [15:0] d, input logic en, input logic [15:0] e);
		logic        ok, n;
		logic [15:0] q;
		host.xfer(w, c, d, ok, n, q);
		chk1("rspValid", 1'b1, ok);
		chk1($sformatf("rspNack %h", c), en, n);
		chk16($sformatf("rspData %h", c), e, q);
	endtask

	// Back-to-back samples; notes the first restart pulse seen
	task automatic heat(input logic [15:0] pk, vl, av, t, input int n,
		output int first);
		first = -1;
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			#1;
			if (restartPulse === 1'b1 && first < 0) begin
				first = i;
			end
			meas = '{1'b1, pk, vl, av, t};
		end
		@(posedge clk);
		#1 meas.valid = 1'b0;
	endtask

	// Clear all status, then let the alert settle
	task automatic clr();
		@(posedge clk);
		#1 clearFaults = 1'b1;
		@(posedge clk);
		#1 clearFaults = 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ==================================================
	// Main sequence
	initial begin
		int d, f, w;
		void'($urandom(93118));
		repeat (6) @(posedge clk);
		#1 reset_n = 1'b1;
		acc(0, CMD_OCW, 0, 0, {5'h1f, 11'd190});
		acc(0, CMD_UCF, 0, 0, UCF_RST);
		acc(0, CMD_OTF, 0, 0, OTF_RST);
		acc(0, CMD_OTA, 0, 0, {8'h00, OTA_RST});
		acc(0, 8'h01, 0, 1, 16'h0000);
		$display("test reset done");
		// Range edges, also with a negative exponent
		w = $urandom_range(99);
		acc(1, CMD_OCW, lin(101), 1, 0);
		acc(1, CMD_OCW, lin(-1), 1, 0);
		acc(1, CMD_OCW, {5'h1f, 11'd201}, 1, 0);
		acc(1, CMD_OCW, {5'h1f, 11'd200}, 0, 0);
		acc(1, CMD_OCW, lin(w), 0, 0);
		acc(0, CMD_OCW, 0, 0, lin(w));
		acc(1, CMD_UCF, lin(-101), 1, 0);
		acc(1, CMD_UCF, lin(101), 1, 0);
		acc(1, CMD_OTF, lin(151), 1, 0);
		acc(1, CMD_OTF, lin(-41), 1, 0);
		acc(0, CMD_UCF, 0, 0, UCF_RST);
		acc(1, CMD_OTF, lin(80), 0, 0);
		$display("test ranges done");
		// Peak warning latches until the host clears it
		heat(lin(w + 1), lin(50), lin(50), lin(25), 1, f);
		acc(0, CMD_IOUT, 0, 0, 16'h0020);
		acc(0, CMD_WORD, 0, 0, 16'h4000);
		chk1("alertN", 1'b0, alertN);
		heat(lin(w), lin(50), lin(50), lin(25), 1, f);
		acc(0, CMD_IOUT, 0, 0, 16'h0020);
		acc(1, CMD_IOUT, 16'h0020, 0, 0);
		acc(0, CMD_IOUT, 0, 0, 16'h0000);
		clr();
		chk1("alertN", 1'b1, alertN);
		$display("test peak done");
		// Valley and averaged checks land on one bit
		// Warning to the top of its range so later peaks of 50 stay quiet
		acc(1, CMD_OCW, lin(100), 0, 0);
		acc(1, CMD_UCF, lin(10), 0, 0);
		heat(lin(50), lin(5), lin(50), lin(25), 1, f);
		acc(0, CMD_IOUT, 0, 0, 16'h0010);
		clr();
		heat(lin(50), lin(20), lin(5), lin(25), 1, f);
		acc(0, CMD_IOUT, 0, 0, 16'h0010);
		clr();
		$display("test undercurrent done");
		// Retry waits for cooling below the warning level
		acc(1, CMD_OTA, 16'h00b8, 0, 0);
		heat(lin(50), lin(50), lin(50), lin(80), 1, f);
		acc(0, CMD_TEMP, 0, 0, 16'h0000);
		heat(lin(50), lin(50), lin(50), lin(90), 1, f);
		acc(0, CMD_TEMP, 0, 0, 16'h0080);
		acc(0, CMD_WORD, 0, 0, 16'h0004);
		acc(0, CMD_VEND, 0, 0, 16'h0002);
		chk1("alertN", 1'b0, alertN);
		heat(lin(50), lin(50), lin(50), lin(70), 40, f);
		chk16("early restart", 16'hffff, 16'(f));
		chk1("outputEnable", 1'b0, outputEnable);
		heat(lin(50), lin(50), lin(50), lin(50), 10, f);
		chk1("restart", 1'b1, f >= 0);
		chk1("outputEnable", 1'b1, outputEnable);
		clr();
		$display("test cooling done");
		// Shut down with no retry stays off until cleared
		acc(1, CMD_OTA, 16'h00c0, 0, 0);
		heat(lin(111), lin(50), lin(50), lin(90), 1, f);
		acc(0, CMD_IOUT, 0, 0, 16'h00a0);
		heat(lin(50), lin(50), lin(50), lin(50), 10, f);
		chk16("latched restart", 16'hffff, 16'(f));
		chk1("outputEnable", 1'b0, outputEnable);
		clr();
		chk1("outputEnable", 1'b1, outputEnable);
		$display("test latch done");
		// Delay from detection, random and largest setting
		for (int k = 0; k < 2; k++) begin
			d = k ? 7 : $urandom_range(6);
			acc(1, CMD_OTA, {8'h00, 5'b10111, d[2:0]}, 0, 0);
			heat(lin(50), lin(50), lin(50), lin(90), 1, f);
			heat(lin(50), lin(50), lin(50), lin(50), 60, f);
			chk1("delay low", 1'b1, f >= (d + 1) * U);
			chk1("delay high", 1'b1, f <= (d + 1) * U + 6);
			clr();
		end
		$display("test delay done");
		conclude();
	end
endmodule
